// >>> hw/chan_err_defs.svh
// Constants shared by the channel error handler: register offsets, field positions, reset values and timing.
`ifndef CHAN_ERR_DEFS_SVH
`define CHAN_ERR_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_STATUS 12'h000
`define OFS_MASK 12'h004
`define OFS_CTRL 12'h008
`define OFS_STATE 12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define ST_FRAME 0
`define ST_MISPLACED 1
`define ST_SCL_STUCK 2
`define ST_SDA_STUCK 3
`define MASK_FRAME 0
`define CTRL_SEQ_START 0
`define CTRL_AUTO_REC 1
`define CTRL_TMO_EN 2
`define CTRL_BUS_REC 3
`define CTRL_FRC_LSB 8
`define CTRL_FRC_MSB 15

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_STATUS 4'h0
`define RST_MASK 1'h0
`define RST_FRC 8'h01

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 25
`define SCL_TMO_US 25000
`define SCL_TMO_CYC ((`SCL_TMO_US * 1000) / `CLK_PERIOD_NS)
`define REC_HALF_NS 5000
`define REC_HALF_CYC ((`REC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_PULSES 9

`endif

// >>> hw/chan_err_pkg.sv
// Types shared by the channel error handler.
package chan_err_pkg;

    // Frame supervision states.
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_WAIT_TRIG = 2'b01,
        FS_RUN = 2'b10,
        FS_TERM = 2'b11
    } frame_state_t;

endpackage

// >>> hw/bus_recovery_gen.sv
// Bus recovery sequencer: clocks SCL a fixed number of times, then checks that SDA is free.
`timescale 1ns/100ps
`include "chan_err_defs.svh"

module bus_recovery_gen #(
    parameter int HALF_CYC = `REC_HALF_CYC,
    parameter int PULSES = `REC_PULSES
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Control.
    input wire logic start_i,
    input wire logic sda_i,
    // Results.
    output logic busy_o,
    output logic done_o,
    output logic ok_o,
    output logic scl_low_o
);

    logic [15:0] tick_q;
    logic [4:0] edge_q;
    logic busy_q;
    logic done_q;
    logic ok_q;
    logic scl_low_q;
    logic last_tick;

    assign last_tick = (tick_q == 16'(HALF_CYC - 1));

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Each pulse is a low half then a released half; SDA is judged only after the last one.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tick_q <= 16'h0000;
            edge_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            scl_low_q <= 1'b0;
        end
        else if (ce_i)
        begin
            done_q <= 1'b0;
            if (!busy_q)
            begin
                if (start_i)
                begin
                    busy_q <= 1'b1;
                    scl_low_q <= 1'b1;
                    tick_q <= 16'h0000;
                    edge_q <= 5'h00;
                end
            end
            else if (!last_tick)
            begin
                tick_q <= tick_q + 16'h0001;
            end
            else
            begin
                tick_q <= 16'h0000;
                scl_low_q <= ~scl_low_q;
                edge_q <= edge_q + 5'h01;
                if (edge_q == 5'(2 * PULSES - 1))
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    ok_q <= sda_i;
                    scl_low_q <= 1'b0;
                end
            end
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign ok_o = ok_q;
    assign scl_low_o = scl_low_q;

endmodule

// >>> hw/chan_err_handler.sv
// Per-channel frame and bus error supervision with an APB register slave.
`timescale 1ns/100ps
`include "chan_err_defs.svh"

// How it works
// R01: Sequence overrunning refresh period or trigger interval raises the frame overrun flag.
// R02: Masked overrun lets the sequence finish; triggers meanwhile do not restart it.
// R03: Masked or not, the total sequence count equals the frame repeat count; the code ends the frame after an unmasked overrun.
// R04: After a masked overrun, the next sequence waits for a later trigger.
// R05: Masked overrun flag stays until status is read; sequences keep running.
// R06: Unmasked overrun ends the sequence orderly, with STOP and an interrupt.
// R07: During reads the engine may take two more bytes before terminating.
// R08: The frame overrun flag is set only when the closing STOP is seen.
// R09: Misplaced START or STOP sets its flag, interrupts, aborts, nothing else.
// R10: Host restores the bus and restarts after a misplaced START/STOP error.
// R11: Stuck SCL past time-out flags, interrupts, aborts; no recovery attempted.
// R12: With auto recovery, failed START on held SDA aborts and recovers silently.
// R13: Successful recovery issues START and resumes at the failed transaction.
// R14: Failed recovery sets SDA stuck flag, interrupts and aborts.
// R15: Without auto recovery, SDA stuck flags, interrupts, aborts, no recovery.
// R16: Host may later request bus recovery through the recovery request bit.
// R17: SDA stuck flag means SDA held low while generating a START.
// R18: Reading channel status clears pending request; interrupt output is active low.
// R19: Mask bit 0 masks frame overrun interrupts; reset value is unmasked.
// R20: Status bits: 3 SDA stuck, 2 SCL stuck, 1 misplaced, 0 frame.
// R21: SCL time-out is a parameter count, gated by the time-out enable.
module chan_err_handler #(
    parameter int SCL_TMO_CYC = `SCL_TMO_CYC,
    parameter int REC_HALF_CYC = `REC_HALF_CYC
) (
    // Clock, reset and enable.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sequence engine, same clock.
    input wire logic trigger_i,
    input wire logic seq_end_i,
    input wire logic in_byte_i,
    input wire logic start_fail_i,
    output logic seq_go_o,
    output logic seq_term_o,
    output logic abort_o,
    output logic resume_start_o,
    // Serial pins.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    // Interrupt.
    output logic int_n_o
);

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [3:0] status_q;
    logic frame_overrun_mask_q;
    logic auto_recovery_enable_q;
    logic tmo_en_q;
    logic [7:0] frame_repeat_count_q;
    logic [7:0] seq_cnt_q;
    logic overrun_pend_q;
    chan_err_pkg::frame_state_t fstate_q;
    logic [31:0] tmo_cnt_q;
    logic [31:0] prdata_q;
    logic go_q;
    logic abort_q;
    logic resume_q;
    logic auto_rec_q;
    logic wr_acc;
    logic rd_setup;
    logic status_read;
    logic seq_start_wr;
    logic bus_recovery_request;
    logic start_seen;
    logic stop_seen;
    logic misplaced;
    logic scl_stuck;
    logic sda_stuck;
    logic rec_start;
    logic rec_busy;
    logic rec_done;
    logic rec_ok;
    logic rec_scl_low;
    logic [3:0] status_set;
    logic mapped;

    // ****************************************************************
    // Pin synchronisers and bus condition detection
    // ****************************************************************
    // Both pins pass two flops; edge detection looks only at the second stage and its delayed copy.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else if (ce_i)
        begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign start_seen = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
    assign stop_seen = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
    // R09: misplaced condition detect
    assign misplaced = (start_seen || stop_seen) && in_byte_i;

    // ****************************************************************
    // SCL stuck-low time-out
    // ****************************************************************
    // R21: gated time-out count
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tmo_cnt_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            if (!tmo_en_q || scl_sync_q[1] || rec_busy)
            begin
                tmo_cnt_q <= 32'h0000_0000;
            end
            else if (tmo_cnt_q != 32'(SCL_TMO_CYC))
            begin
                tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Fires once as the count reaches the limit, so the flag is not re-raised each cycle.
    assign scl_stuck = tmo_en_q && !scl_sync_q[1] && !rec_busy && (tmo_cnt_q == 32'(SCL_TMO_CYC - 1));

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign mapped = (paddr_i == `OFS_STATUS) || (paddr_i == `OFS_MASK) ||
                    (paddr_i == `OFS_CTRL) || (paddr_i == `OFS_STATE);
    // R18: status read clears
    assign status_read = ce_i && psel_i && penable_i && !pwrite_i && (paddr_i == `OFS_STATUS);
    assign seq_start_wr = ce_i && wr_acc && (paddr_i == `OFS_CTRL) && pwdata_i[`CTRL_SEQ_START];
    // R16: host recovery request
    assign bus_recovery_request = ce_i && wr_acc && (paddr_i == `OFS_CTRL) && pwdata_i[`CTRL_BUS_REC];
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_q;

    // Read data is captured in the setup phase so that pready can stay high.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (ce_i && rd_setup)
        begin
            if (paddr_i == `OFS_STATUS)
            begin
                prdata_q <= {28'h000_0000, status_q};
            end
            else if (paddr_i == `OFS_MASK)
            begin
                prdata_q <= {31'h0000_0000, frame_overrun_mask_q};
            end
            else if (paddr_i == `OFS_CTRL)
            begin
                prdata_q <= {16'h0000, frame_repeat_count_q, 4'h0, rec_busy, tmo_en_q, auto_recovery_enable_q, 1'b0};
            end
            else if (paddr_i == `OFS_STATE)
            begin
                prdata_q <= {16'h0000, seq_cnt_q, 3'h0, overrun_pend_q, rec_busy, auto_rec_q, fstate_q};
            end
            else
            begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            frame_overrun_mask_q <= `RST_MASK;
            auto_recovery_enable_q <= 1'b0;
            tmo_en_q <= 1'b0;
            frame_repeat_count_q <= `RST_FRC;
        end
        else if (ce_i && wr_acc)
        begin
            if (paddr_i == `OFS_MASK)
            begin
                // R19: frame mask bit
                frame_overrun_mask_q <= pwdata_i[`MASK_FRAME];
            end
            else if (paddr_i == `OFS_CTRL)
            begin
                auto_recovery_enable_q <= pwdata_i[`CTRL_AUTO_REC];
                tmo_en_q <= pwdata_i[`CTRL_TMO_EN];
                frame_repeat_count_q <= pwdata_i[`CTRL_FRC_MSB:`CTRL_FRC_LSB];
            end
        end
    end

    // ****************************************************************
    // Frame supervision
    // ****************************************************************
    // R02: triggers ignored while running masked
    // R03: sequence count limit
    // R04: restart on later trigger
    // R06: unmasked orderly termination
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fstate_q <= chan_err_pkg::FS_IDLE;
            seq_cnt_q <= 8'h00;
            overrun_pend_q <= 1'b0;
            go_q <= 1'b0;
        end
        else if (ce_i)
        begin
            go_q <= 1'b0;
            case (fstate_q)
                chan_err_pkg::FS_IDLE:
                begin
                    if (seq_start_wr && frame_repeat_count_q != 8'h00)
                    begin
                        seq_cnt_q <= 8'h00;
                        fstate_q <= chan_err_pkg::FS_WAIT_TRIG;
                    end
                end
                chan_err_pkg::FS_WAIT_TRIG:
                begin
                    if (trigger_i)
                    begin
                        go_q <= 1'b1;
                        seq_cnt_q <= seq_cnt_q + 8'h01;
                        fstate_q <= chan_err_pkg::FS_RUN;
                    end
                end
                chan_err_pkg::FS_RUN:
                begin
                    if (abort_q)
                    begin
                        fstate_q <= chan_err_pkg::FS_IDLE;
                    end
                    else if (seq_end_i)
                    begin
                        fstate_q <= (seq_cnt_q == frame_repeat_count_q) ? chan_err_pkg::FS_IDLE
                                                                       : chan_err_pkg::FS_WAIT_TRIG;
                    end
                    else if (trigger_i)
                    begin
                        // R01: overrun detection
                        overrun_pend_q <= 1'b1;
                        if (!frame_overrun_mask_q)
                        begin
                            fstate_q <= chan_err_pkg::FS_TERM;
                        end
                    end
                end
                chan_err_pkg::FS_TERM:
                begin
                    // R07: engine may finish up to two read bytes
                    if (stop_seen || abort_q)
                    begin
                        fstate_q <= chan_err_pkg::FS_IDLE;
                    end
                end
                default:
                begin
                    fstate_q <= chan_err_pkg::FS_IDLE;
                end
            endcase
            // R08: flag waits for the closing STOP
            if (overrun_pend_q && stop_seen && fstate_q != chan_err_pkg::FS_RUN)
            begin
                overrun_pend_q <= 1'b0;
            end
        end
    end

    assign seq_go_o = go_q;
    assign seq_term_o = (fstate_q == chan_err_pkg::FS_TERM);

    // ****************************************************************
    // Bus error reactions and recovery
    // ****************************************************************
    assign sda_stuck = start_fail_i && !sda_sync_q[1];
    assign rec_start = (ce_i && sda_stuck && auto_recovery_enable_q && !rec_busy) || bus_recovery_request;

    // R12: abort and recover on held SDA
    // R13: resume with START on success
    // R11: abort without recovery on stuck clock
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            abort_q <= 1'b0;
            resume_q <= 1'b0;
            auto_rec_q <= 1'b0;
        end
        else if (ce_i)
        begin
            abort_q <= misplaced || scl_stuck || sda_stuck;
            resume_q <= rec_done && rec_ok && auto_rec_q;
            if (sda_stuck && auto_recovery_enable_q && !rec_busy)
            begin
                auto_rec_q <= 1'b1;
            end
            else if (rec_done)
            begin
                auto_rec_q <= 1'b0;
            end
        end
    end

    assign abort_o = abort_q;
    assign resume_start_o = resume_q;

    bus_recovery_gen #(
        .HALF_CYC(REC_HALF_CYC),
        .PULSES(`REC_PULSES)
    ) u_recovery (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(rec_start),
        .sda_i(sda_sync_q[1]),
        .busy_o(rec_busy),
        .done_o(rec_done),
        .ok_o(rec_ok),
        .scl_low_o(rec_scl_low)
    );

    // Open drain: the pin is only ever pulled low, enable low means driving.
    assign scl_o = 1'b0;
    assign scl_oe_n_o = !rec_scl_low;

    // ****************************************************************
    // Channel status and interrupt
    // ****************************************************************
    // R20: status bit placement
    // R14: failed auto recovery flags SDA stuck
    // R15: no auto recovery flags SDA stuck at once
    // R17: SDA stuck at START
    assign status_set[`ST_FRAME] = overrun_pend_q && stop_seen && fstate_q != chan_err_pkg::FS_RUN;
    assign status_set[`ST_MISPLACED] = misplaced;
    assign status_set[`ST_SCL_STUCK] = scl_stuck;
    assign status_set[`ST_SDA_STUCK] = (sda_stuck && !auto_recovery_enable_q) || (rec_done && !rec_ok && auto_rec_q);

    // R05: held until the status read; a new event in the read cycle survives.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status_q <= `RST_STATUS;
        end
        else if (ce_i)
        begin
            status_q <= (status_q & {4{!status_read}}) | status_set;
        end
    end

    // R18: active low shared request
    assign int_n_o = !(|status_q[`ST_SDA_STUCK:`ST_MISPLACED] ||
                       (status_q[`ST_FRAME] && !frame_overrun_mask_q));

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_masked_overrun;
        fstate_q == chan_err_pkg::FS_RUN && trigger_i && !seq_end_i && !abort_q && frame_overrun_mask_q && ce_i;
    endsequence

    a_masked_no_restart: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R02
        s_masked_overrun |=> fstate_q == chan_err_pkg::FS_RUN && !go_q)
        else $error("masked overrun left the running state");
    a_unmasked_term: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R06
        fstate_q == chan_err_pkg::FS_RUN && trigger_i && !seq_end_i && !abort_q && !frame_overrun_mask_q && ce_i
        |=> seq_term_o)
        else $error("unmasked overrun did not request termination");
    a_count_limit: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R03
        go_q |-> seq_cnt_q <= frame_repeat_count_q && seq_cnt_q != 8'h00)
        else $error("more sequences than the repeat count");
    a_frame_on_stop: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R08
        $rose(status_q[`ST_FRAME]) |-> $past(stop_seen) && $past(overrun_pend_q))
        else $error("frame flag set without the closing STOP");
    a_misplaced_abort: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
        misplaced && ce_i |=> abort_q && status_q[`ST_MISPLACED] && !int_n_o)
        else $error("misplaced START/STOP not flagged and aborted");
    a_scl_stuck_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
        scl_stuck && ce_i |=> abort_q && status_q[`ST_SCL_STUCK] && !int_n_o)
        else $error("stuck clock not flagged and aborted");
    a_auto_rec_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
        sda_stuck && auto_recovery_enable_q && !rec_busy && ce_i
        |=> abort_q && rec_busy && !status_set[`ST_SDA_STUCK])
        else $error("auto recovery did not start quietly");
    a_rec_resume: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
        rec_done && rec_ok && auto_rec_q && ce_i |=> resume_start_o)
        else $error("no START after successful recovery");
    a_status_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
        status_read && status_set == 4'h0 |=> status_q == 4'h0 && int_n_o)
        else $error("status read did not clear the request");
    a_mask_frame: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R19
        status_q == 4'h1 && frame_overrun_mask_q |-> int_n_o)
        else $error("masked frame flag raised the interrupt");

endmodule

// >>> bench/i2c_slave_model.sv
// Behavioural slave side of the serial bus: open-drain lines that can be held low on command.
`timescale 1ns/100ps

module i2c_slave_model (
    // Commands from the bench.
    input wire logic hold_scl_i,
    input wire logic hold_sda_i,
    // Master drive.
    input wire logic scl_oe_n_i,
    // Wire levels.
    output logic scl_o,
    output logic sda_o
);
    // Any party pulling low wins; a released line returns to its pull-up level.
    // clock line held low
    assign scl_o = scl_oe_n_i & ~hold_scl_i;
    assign sda_o = ~hold_sda_i;
endmodule

// >>> bench/tb_i2c_channel_error_handler.sv
// Self-checking bench for the channel error handler.
`timescale 1ns/100ps

module tb_i2c_channel_error_handler;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} row_t;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic trigger = 1'b0, seq_end = 1'b0, in_byte = 1'b0, start_fail = 1'b0, hold_scl = 1'b0, hold_sda = 1'b0;
    logic seq_go, seq_term, abort, resume, scl_w, sda_w, scl_drv, scl_oe_n, int_n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    int miscompares = 0, n_checks = 0, n_go = 0, n_abort = 0, n_res = 0, n_rec = 0, k0;
    // Reset values and the unmapped place; the reserved address answers with an error and zero.
    row_t rows [5] = '{{12'h000, 32'h0, 1'b0}, {12'h004, 32'h0, 1'b0}, {12'h008, 32'h100, 1'b0},
                       {12'h00c, 32'h0, 1'b0}, {12'h010, 32'h0, 1'b1}};

    always #12.5 mclk_i = ~mclk_i;

    chan_err_handler #(.SCL_TMO_CYC(50), .REC_HALF_CYC(2)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trigger_i(trigger), .seq_end_i(seq_end),
        .in_byte_i(in_byte), .start_fail_i(start_fail), .seq_go_o(seq_go), .seq_term_o(seq_term), .abort_o(abort),
        .resume_start_o(resume), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n), .int_n_o(int_n));
    i2c_slave_model slave_u (.hold_scl_i(hold_scl), .hold_sda_i(hold_sda), .scl_oe_n_i(scl_oe_n), .scl_o(scl_w),
        .sda_o(sda_w));

    // Go, abort and resume pulses last one cycle, so they are counted at every edge rather than polled.
    always @(posedge mclk_i)
    begin
        n_go <= n_go + int'(seq_go === 1'b1);
        n_abort <= n_abort + int'(abort === 1'b1);
        n_res <= n_res + int'(resume === 1'b1);
        n_rec <= n_rec + int'(scl_oe_n === 1'b0);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
            miscompares++;
        end
    endtask

    // The request is held until pready is seen high at a rising edge, then released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do
        begin
            tick(1);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask

    task automatic pulse(input int s);
        case (s)
            0: trigger <= 1'b1;
            1: seq_end <= 1'b1;
            default: start_fail <= 1'b1;
        endcase
        tick(1);
        {trigger, seq_end, start_fail} <= 3'b000;
        tick(2);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        tick(4);
        rst_n_i <= 1'b1;
        tick(1);
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(r, rows[i].d, "reset read");
            chk({31'h0, e}, {31'h0, rows[i].e}, "slave error");
        end
        $display("test reset done");
        apb(1'b1, 12'h008, 32'h101);
        pulse(0);
        pulse(0);
        chk({31'h0, seq_term}, 32'h1, "orderly stop");
        hold_sda <= 1'b1;
        tick(4);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0, "flag before stop");
        hold_sda <= 1'b0;
        tick(6);
        chk({31'h0, int_n}, 32'h0, "overrun interrupt");
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h1, "overrun flag");
        chk({31'h0, int_n}, 32'h1, "read clears");
        $display("test unmasked overrun done");
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h008, 32'h201);
        pulse(0);
        pulse(0);
        pulse(0);
        chk({31'h0, seq_term}, 32'h0, "masked keeps running");
        pulse(1);
        hold_sda <= 1'b1;
        tick(4);
        hold_sda <= 1'b0;
        tick(6);
        chk({31'h0, int_n}, 32'h1, "masked no interrupt");
        pulse(0);
        pulse(1);
        pulse(0);
        chk(n_go, 32'd3, "sequence count");
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h1, "masked flag held");
        $display("test masked overrun done");
        k0 = n_abort;
        in_byte <= 1'b1;
        hold_sda <= 1'b1;
        tick(6);
        chk({31'h0, int_n}, 32'h0, "misplaced interrupt");
        chk(32'(n_abort > k0), 32'h1, "misplaced abort");
        in_byte <= 1'b0;
        hold_sda <= 1'b0;
        tick(4);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h2, "misplaced flag");
        $display("test misplaced done");
        k0 = n_abort;
        apb(1'b1, 12'h008, 32'h104);
        // the slave holds SCL low past the time-out
        hold_scl <= 1'b1;
        tick(60);
        chk({31'h0, int_n}, 32'h0, "stuck clock interrupt");
        hold_scl <= 1'b0;
        tick(4);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h4, "stuck clock flag");
        chk(n_abort - k0, 32'd1, "stuck clock abort");
        chk(n_rec, 32'd0, "no recovery pulses");
        $display("test stuck clock done");
        apb(1'b1, 12'h008, 32'h100);
        hold_sda <= 1'b1;
        tick(4);
        pulse(2);
        tick(4);
        chk({31'h0, int_n}, 32'h0, "stuck data interrupt");
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h8, "stuck data flag");
        chk(n_rec, 32'd0, "no auto recovery");
        hold_sda <= 1'b0;
        tick(4);
        // host asks for a recovery by itself
        apb(1'b1, 12'h008, 32'h108);
        tick(60);
        chk(32'(n_rec > 0), 32'h1, "host recovery");
        chk(32'(scl_drv), 32'h0, "scl drive");
        chk(n_res, 32'd0, "no resume on host recovery");
        $display("test stuck data done");
        apb(1'b1, 12'h008, 32'h102);
        hold_sda <= 1'b1;
        tick(4);
        pulse(2);
        hold_sda <= 1'b0;
        tick(80);
        chk(n_res, 32'd1, "resume after recovery");
        chk({31'h0, int_n}, 32'h1, "silent recovery");
        hold_sda <= 1'b1;
        tick(4);
        pulse(2);
        tick(80);
        chk({31'h0, int_n}, 32'h0, "failed recovery interrupt");
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h8, "failed recovery flag");
        chk(n_res, 32'd1, "no resume on failure");
        $display("test auto recovery done");
        complete_run();
    end

    // Watchdog: the whole sequence needs well under two thousand cycles.
    initial
    begin
        tick(5000);
        miscompares++;
        complete_run();
    end
endmodule
